// *** rtl/srsc_pkg.sv ***
// Shared constants for the soft reboot and self-check control link
package srsc_pkg;

   // ==========================================================
   // Device register map
   localparam logic [7:0] MODE_CTRL_ADDR    = 8'h2A;
   localparam logic [7:0] RST_OSR_CTRL_ADDR = 8'h2B;
   localparam logic [7:0] MODE_CTRL_RST     = 8'h00;
   localparam logic [7:0] RST_OSR_CTRL_RST  = 8'h00;

   // ==========================================================
   // Field positions
   localparam int MODE_ACTIVE_BIT  = 0;
   localparam int SELF_CHECK_BIT   = 7;
   localparam int REBOOT_BIT       = 6;
   localparam int SLEEP_OSR_LSB    = 3;
   localparam int AUTO_SLEEP_BIT   = 2;
   localparam int WAKE_OSR_LSB     = 0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS    = 8;
   localparam int STBY_TIME_NS     = 80;
   localparam int BOOT_TIME_NS     = 400;
   localparam int PIN_PULSE_NS     = 40;
   localparam int QUIET_TIME_US    = 1000;
   localparam logic [7:0] STBY_CYC =
      8'((STBY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] BOOT_CYC =
      8'((BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] PIN_PULSE_CYC =
      8'((PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int QUIET_CYC_DEF    =
      (QUIET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Host APB register map
   localparam logic [7:0] HOST_CMD_ADDR    = 8'h00;
   localparam logic [7:0] HOST_STATUS_ADDR = 8'h04;
   localparam logic [7:0] HOST_PINRST_ADDR = 8'h08;
   localparam int CMD_WDATA_LSB    = 8;
   localparam int CMD_WRITE_BIT    = 16;
   localparam int ST_BUSY_BIT      = 0;
   localparam int ST_DONE_BIT      = 1;
   localparam int ST_NOACK_BIT     = 2;
   localparam int ST_RDATA_LSB     = 8;

   // ==========================================================
   // State encodings
   typedef enum logic [2:0] {
      DEV_RUN  = 3'h1,
      DEV_STBY = 3'h2,
      DEV_BOOT = 3'h4
   } srsc_dev_state_e;

   typedef enum logic [3:0] {
      HST_IDLE  = 4'h1,
      HST_REQ   = 4'h2,
      HST_PIN   = 4'h4,
      HST_QUIET = 4'h8
   } srsc_host_state_e;

endpackage

// *** rtl/srsc_link_if.sv ***
// Register link between host controller and sensor device
`timescale 1ns/100ps
interface srsc_link_if;
   logic       req;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   logic       rst_pin;

   modport dev
   (
      input  req,
      input  we,
      input  addr,
      input  wdata,
      input  rst_pin,
      output ack,
      output rdata
   );

   modport host
   (
      output req,
      output we,
      output addr,
      output wdata,
      output rst_pin,
      input  ack,
      input  rdata
   );
endinterface

// *** rtl/srsc_device.sv ***
// Sensor side: control registers, reboot sequencer and self-check enable
//
// Overview of operation
// - 8-bit control register at 0x2B, resets zero
// - Self-check bit drives accelerometer self-check output
// - Writing reboot bit one starts software reset
// - Reboot accepted in standby and active mode
// - Reboot restores every register default
// - Active device first moves to standby, then reboots
// - Standby device begins reboot at once
// - External reset pin pulse reboots at once, active or not, without the standby step
// - Host waits 1 ms before next transaction
// - Host keeps shared bus quiet during 1 ms
// - Reboot resets interface, dropping partial transactions
// - Reboot write over link gets no acknowledge
// - Host treats missing reboot acknowledge as normal
// - Hardware clears reboot bit when boot completes
// - Mode bit: zero standby, one active
`timescale 1ns/100ps
module srsc_device
   import srsc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   srsc_link_if.dev        lk,
   output logic            self_check_on,
   output logic            active_mode,
   output logic            auto_sleep_en,
   output logic [1:0]      sleep_osr,
   output logic [1:0]      wake_osr,
   output logic            booting
);

   // ==========================================================
   // Registers
   srsc_dev_state_e state_reg;
   srsc_dev_state_e state_next;
   logic [7:0]      mode_reg;
   logic [7:0]      mode_next;
   logic [7:0]      ctrl_reg;
   logic [7:0]      ctrl_next;
   // One down-counter times both the standby wind-down and the reload
   logic [7:0]      cnt_reg;
   logic [7:0]      cnt_next;
   logic            ack_reg;
   logic            ack_next;
   logic [7:0]      rdata_reg;
   logic [7:0]      rdata_next;

   // ==========================================================
   // Link decode
   // Only run state takes a request; one that arrives in standby or boot
   // is ignored whole, so no transfer is left half done
   wire       take       = (state_reg == DEV_RUN) && lk.req && !ack_reg;
   wire       hit_mode   = (lk.addr == MODE_CTRL_ADDR);
   wire       hit_ctrl   = (lk.addr == RST_OSR_CTRL_ADDR);
   wire       wr_mode    = take && lk.we && hit_mode;
   wire       wr_ctrl    = take && lk.we && hit_ctrl;
   wire       reboot_wr  = wr_ctrl && lk.wdata[REBOOT_BIT];
   wire       is_active  = mode_reg[MODE_ACTIVE_BIT];
   wire       cnt_done   = (cnt_reg == 8'h00);
   wire [7:0] cnt_dec    = cnt_reg - 8'h01;
   // Unmapped addresses read as zero and ignore writes
   wire [7:0] read_mux   = hit_mode ? mode_reg :
                           hit_ctrl ? ctrl_reg : 8'h00;

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      state_next = state_reg;
      mode_next  = mode_reg;
      ctrl_next  = ctrl_reg;
      cnt_next   = cnt_reg;
      ack_next   = 1'b0;
      rdata_next = rdata_reg;
      case (state_reg)
         DEV_RUN:
         begin
            if (reboot_wr)
            begin
               // Request taken in either mode; no acknowledge goes back
               ctrl_next = lk.wdata;
               // An active device settles in standby first, so a reboot write never
               // reloads the sensors in the middle of a conversion
               if (is_active)
               begin
                  state_next = DEV_STBY;
                  cnt_next   = STBY_CYC;
               end
               else
               begin
                  state_next = DEV_BOOT;
                  cnt_next   = BOOT_CYC;
               end
            end
            else if (take)
            begin
               // Ordinary access: one-cycle ack, read data held until the next read or a reboot
               ack_next = 1'b1;
               if (wr_ctrl)
               begin
                  ctrl_next = lk.wdata;
               end
               if (wr_mode)
               begin
                  mode_next = lk.wdata;
               end
               if (!lk.we)
               begin
                  rdata_next = read_mux;
               end
            end
         end
         DEV_STBY:
         begin
            // Sensors are winding down; the link stays deaf meanwhile
            // The mode bit falls only when the count runs out, so software
            // still sees the device active during the wind-down
            if (cnt_done)
            begin
               mode_next[MODE_ACTIVE_BIT] = 1'b0;
               state_next = DEV_BOOT;
               cnt_next   = BOOT_CYC;
            end
            else
            begin
               cnt_next = cnt_dec;
            end
         end
         DEV_BOOT:
         begin
            // Defaults reloaded while the reboot bit stays visible
            mode_next = MODE_CTRL_RST;
            ctrl_next = RST_OSR_CTRL_RST;
            ctrl_next[REBOOT_BIT] = 1'b1;
            rdata_next = 8'h00;
            // Last boot cycle: the reboot bit drops and the link reopens
            if (cnt_done)
            begin
               ctrl_next  = RST_OSR_CTRL_RST;
               state_next = DEV_RUN;
            end
            else
            begin
               cnt_next = cnt_dec;
            end
         end
         default:
         begin
            state_next = DEV_BOOT;
            cnt_next   = BOOT_CYC;
         end
      endcase

      // The pin overrides any sequence in progress and restarts the boot
      // It acts on level: a long pulse keeps the count at its start value,
      // so the full reload still follows the falling edge
      if (lk.rst_pin)
      begin
         state_next = DEV_BOOT;
         cnt_next   = BOOT_CYC;
         ack_next   = 1'b0;
         ctrl_next  = RST_OSR_CTRL_RST;
         ctrl_next[REBOOT_BIT] = 1'b1;
         mode_next  = MODE_CTRL_RST;
      end
   end

   // ==========================================================
   // Flip-flops
   // rst only covers power-up; a soft reboot and the pin both go through
   // the boot state, so they leave the same state behind
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= DEV_RUN;
         mode_reg  <= MODE_CTRL_RST;
         ctrl_reg  <= RST_OSR_CTRL_RST;
         cnt_reg   <= 8'h00;
         ack_reg   <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         ctrl_reg  <= ctrl_next;
         cnt_reg   <= cnt_next;
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Outputs, each taken straight from register bits
   assign lk.ack        = ack_reg;
   assign lk.rdata      = rdata_reg;
   assign self_check_on = ctrl_reg[SELF_CHECK_BIT];
   assign active_mode   = mode_reg[MODE_ACTIVE_BIT];
   assign auto_sleep_en = ctrl_reg[AUTO_SLEEP_BIT];
   assign sleep_osr     = ctrl_reg[SLEEP_OSR_LSB +: 2];
   assign wake_osr      = ctrl_reg[WAKE_OSR_LSB +: 2];
   // One-hot state code, so the boot bit itself is the busy flag
   assign booting       = state_reg[2];

endmodule // srsc_device

// *** rtl/srsc_host.sv ***
// Host side: APB-controlled link master with reset quiet time
`timescale 1ns/100ps
module srsc_host
   import srsc_pkg::*;
#(
   parameter int QUIET_CYC = QUIET_CYC_DEF
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   srsc_link_if.host        lk
);

   // ==========================================================
   // Registers
   srsc_host_state_e state_reg;
   logic [16:0]      cmd_reg;
   logic             done_reg;
   logic             noack_reg;
   logic [7:0]       rdata_reg;
   logic [16:0]      cnt_reg;
   logic             req_reg;
   logic             pin_reg;
   logic [31:0]      prdata_reg;
   logic             pready_reg;
   logic             pslverr_reg;

   // ==========================================================
   // APB decode; no wait state, ready and read data registered in the setup cycle
   wire        setup     = psel && !penable;
   wire        commit    = psel && penable && pready_reg;
   wire        wr_cmd    = commit && pwrite && (paddr == HOST_CMD_ADDR);
   wire        wr_stat   = commit && pwrite && (paddr == HOST_STATUS_ADDR);
   wire        wr_pin    = commit && pwrite && (paddr == HOST_PINRST_ADDR);
   wire        mapped    = (paddr == HOST_CMD_ADDR) || (paddr == HOST_STATUS_ADDR)
                           || (paddr == HOST_PINRST_ADDR);
   wire        idle      = (state_reg == HST_IDLE);
   wire        busy      = !idle;
   wire        reboot_cmd = cmd_reg[CMD_WRITE_BIT]
                           && (cmd_reg[7:0] == RST_OSR_CTRL_ADDR)
                           && cmd_reg[CMD_WDATA_LSB + REBOOT_BIT];
   wire        cnt_done  = (cnt_reg == 17'h00000);
   wire [31:0] status    = {16'h0000, rdata_reg, 5'h00, noack_reg, done_reg, busy};
   wire [31:0] read_mux  = (paddr == HOST_CMD_ADDR)    ? {15'h0000, cmd_reg} :
                           (paddr == HOST_STATUS_ADDR) ? status : 32'h0000_0000;
   wire        go_cmd    = wr_cmd && idle;
   wire        go_pin    = wr_pin && pwdata[0] && idle;
   wire        got_ack   = (state_reg == HST_REQ) && req_reg && lk.ack;
   wire        clr_done  = wr_stat && pwdata[ST_DONE_BIT];

   // ==========================================================
   // APB slave
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= setup;
         prdata_reg  <= setup ? read_mux : 32'h0000_0000;
         pslverr_reg <= setup && !mapped;
      end
   end

   // ==========================================================
   // Link sequencer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= HST_IDLE;
         cmd_reg   <= 17'h00000;
         done_reg  <= 1'b0;
         noack_reg <= 1'b0;
         rdata_reg <= 8'h00;
         cnt_reg   <= 17'h00000;
         req_reg   <= 1'b0;
         pin_reg   <= 1'b0;
      end
      else
      begin
         // A completion in the same cycle as a clear keeps the flag set
         if (clr_done)
         begin
            done_reg  <= 1'b0;
            noack_reg <= 1'b0;
         end
         if (go_cmd)
         begin
            cmd_reg <= pwdata[16:0];
         end
         case (state_reg)
            HST_IDLE:
            begin
               if (go_cmd)
               begin
                  state_reg <= HST_REQ;
                  req_reg   <= 1'b1;
               end
               else if (go_pin)
               begin
                  state_reg <= HST_PIN;
                  pin_reg   <= 1'b1;
                  cnt_reg   <= {9'h000, PIN_PULSE_CYC};
               end
            end
            HST_REQ:
            begin
               if (reboot_cmd)
               begin
                  // One-cycle offer, then no wait for an acknowledge
                  req_reg   <= 1'b0;
                  noack_reg <= 1'b1;
                  state_reg <= HST_QUIET;
                  cnt_reg   <= 17'(QUIET_CYC);
               end
               else if (got_ack)
               begin
                  req_reg   <= 1'b0;
                  rdata_reg <= lk.rdata;
                  done_reg  <= 1'b1;
                  state_reg <= HST_IDLE;
               end
            end
            HST_PIN:
            begin
               if (cnt_done)
               begin
                  pin_reg   <= 1'b0;
                  state_reg <= HST_QUIET;
                  cnt_reg   <= 17'(QUIET_CYC);
               end
               else
               begin
                  cnt_reg <= cnt_reg - 17'h00001;
               end
            end
            HST_QUIET:
            begin
               // Link held silent so the device sees no traffic
               if (cnt_done)
               begin
                  done_reg  <= 1'b1;
                  state_reg <= HST_IDLE;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 17'h00001;
               end
            end
            default:
            begin
               state_reg <= HST_IDLE;
               req_reg   <= 1'b0;
               pin_reg   <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   assign prdata   = prdata_reg;
   assign pready   = pready_reg;
   assign pslverr  = pslverr_reg;
   assign lk.req   = req_reg;
   assign lk.we    = cmd_reg[CMD_WRITE_BIT];
   assign lk.addr  = cmd_reg[7:0];
   assign lk.wdata = cmd_reg[CMD_WDATA_LSB +: 8];
   assign lk.rst_pin = pin_reg;

endmodule // srsc_host

// *** verification/srsc_sva.sv ***
// Link protocol checker for the soft reboot and self-check control link
`timescale 1ns/100ps
module srsc_sva
   import srsc_pkg::*;
#(
   parameter int QUIET_CYC = QUIET_CYC_DEF
)
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       req,
   input wire logic       we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       ack,
   input wire logic [7:0] rdata,
   input wire logic       rst_pin
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // Helper logic
   wire logic reboot_w = req && we && (addr == RST_OSR_CTRL_ADDR) && wdata[REBOOT_BIT];
   int        quiet_cnt;

   // Counts idle cycles since the last reboot write or pin pulse; saturates
   always_ff @(posedge clk)
      if (rst)
         quiet_cnt <= 0;
      else if (rst_pin || reboot_w)
         quiet_cnt <= 1;
      else if (quiet_cnt != 0 && quiet_cnt < 100000)
         quiet_cnt <= quiet_cnt + 1;

   // ==========================================================
   // Properties
   property p_ack_answer;
      $rose(req) && !reboot_w |=> ack;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
   property p_ack_pulse;
      ack |=> !ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause;
      ack |-> req && $past(req);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_noack_reboot;
      $rose(req) && reboot_w |=> !ack [*8];
   endproperty
   a_noack_reboot: assert property (p_noack_reboot) else $error("reboot write acked");
   property p_reboot_release;
      reboot_w |=> !req;
   endproperty
   a_reboot_release: assert property (p_reboot_release) else $error("host waits on reboot");
   property p_req_hold;
      req && !ack && !reboot_w |=> req && $stable({we, addr, wdata});
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
   property p_ack_release;
      ack |=> !req;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("request kept after ack");
   property p_quiet;
      $rose(req) |-> (quiet_cnt == 0) || (quiet_cnt >= QUIET_CYC);
   endproperty
   a_quiet: assert property (p_quiet) else $error("request inside quiet time");
   property p_pin_pulse;
      $rose(rst_pin) |-> rst_pin [*6] ##1 !rst_pin;
   endproperty
   a_pin_pulse: assert property (p_pin_pulse) else $error("reset pin pulse width wrong");
   property p_pin_quiet;
      rst_pin |-> !req;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("request during reset pin");
endmodule // srsc_sva

// *** verification/testbench.sv ***
// Testbench joining host and device ends over the register link
`timescale 1ns/100ps
module testbench
   import srsc_pkg::*;
;
   localparam int QC = 200;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, st, rd;
   logic        pready, pslverr, sc, am, asl, booting, err;
   logic [1:0]  sosr, wosr;
   logic [7:0]  flds;
   int          miscompares = 0, n_checks = 0, cyc = 0, t_req = 0, t_boot = 0, nboot = 0;
   logic        req_d = 0, boot_d = 0;

   always #4 clk = ~clk;
   assign flds = {sc, am, asl, sosr, wosr, booting};

   srsc_link_if lk_if ();
   srsc_host #(.QUIET_CYC(QC)) srsc_host_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lk(lk_if.host));
   srsc_device srsc_device_inst (.clk(clk), .rst(rst), .lk(lk_if.dev), .self_check_on(sc),
      .active_mode(am), .auto_sleep_en(asl), .sleep_osr(sosr), .wake_osr(wosr),
      .booting(booting));
   srsc_sva #(.QUIET_CYC(QC)) srsc_sva_inst (.clk(clk), .rst(rst), .req(lk_if.req),
      .we(lk_if.we), .addr(lk_if.addr), .wdata(lk_if.wdata), .ack(lk_if.ack),
      .rdata(lk_if.rdata), .rst_pin(lk_if.rst_pin));

   // ==========================================================
   // Timing monitor: request start, boot start and boot length
   always @(posedge clk)
   begin
      cyc++;
      if (lk_if.req === 1'b1 && !req_d) t_req = cyc;
      if (booting === 1'b1 && !boot_d) t_boot = cyc;
      if (booting === 1'b1) nboot++;
      req_d = (lk_if.req === 1'b1);
      boot_d = (booting === 1'b1);
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Polls status until idle, then clears done and noack
   task automatic lnk(input logic wr, input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, HOST_CMD_ADDR, {15'h0000, wr, d, a}, rd, err);
      do apb(1'b0, HOST_STATUS_ADDR, 32'h0000_0000, st, err); while (st[ST_BUSY_BIT] !== 1'b0);
      apb(1'b1, HOST_STATUS_ADDR, 32'h0000_0002, rd, err);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end

   // ==========================================================
   // Tests
   initial
   begin
      int nb;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("fields", flds, 8'h00);
      lnk(1'b0, RST_OSR_CTRL_ADDR, 8'h00);
      chk("ctrl_read", st[15:8], RST_OSR_CTRL_RST);
      $display("test reset values done");
      lnk(1'b1, RST_OSR_CTRL_ADDR, 8'hBF);
      chk("fields", flds, 8'hBE);
      lnk(1'b0, RST_OSR_CTRL_ADDR, 8'h00);
      chk("ctrl_read", st[15:8], 8'hBF);
      lnk(1'b1, MODE_CTRL_ADDR, 8'h01);
      chk("fields", flds, 8'hFE);
      $display("test field write done");
      nb = nboot;
      lnk(1'b1, RST_OSR_CTRL_ADDR, 8'hC2);
      chk("noack", st[ST_NOACK_BIT], 1'b1);
      chk("stby_delay", 32'(t_boot - t_req > STBY_CYC), 32'h1);
      chk("boot_len", nboot - nb, BOOT_CYC + 1);
      chk("fields", flds, 8'h00);
      lnk(1'b0, RST_OSR_CTRL_ADDR, 8'h00);
      chk("ctrl_read", st[15:8], 8'h00);
      lnk(1'b0, MODE_CTRL_ADDR, 8'h00);
      chk("mode_read", st[15:8], MODE_CTRL_RST);
      $display("test reboot from active done");
      lnk(1'b1, RST_OSR_CTRL_ADDR, 8'hC0);
      chk("boot_delay", t_boot - t_req, 32'h1);
      chk("fields", flds, 8'h00);
      $display("test reboot from standby done");
      nb = nboot;
      lnk(1'b1, RST_OSR_CTRL_ADDR, 8'h01);
      chk("noack", st[ST_NOACK_BIT], 1'b0);
      chk("no_boot", nboot - nb, 32'h0);
      lnk(1'b1, MODE_CTRL_ADDR, 8'h01);
      chk("fields", flds, 8'h42);
      $display("test reboot bit clear done");
      apb(1'b1, HOST_PINRST_ADDR, 32'h0000_0001, rd, err);
      do apb(1'b0, HOST_STATUS_ADDR, 32'h0000_0000, st, err); while (st[ST_BUSY_BIT] !== 1'b0);
      chk("fields", flds, 8'h00);
      lnk(1'b0, RST_OSR_CTRL_ADDR, 8'h00);
      chk("ctrl_read", st[15:8], 8'h00);
      $display("test pin reset done");
      apb(1'b0, HOST_CMD_ADDR, 32'h0000_0000, rd, err);
      chk("cmd_slverr", err, 1'b0);
      chk("cmd_read", rd, {24'h000000, RST_OSR_CTRL_ADDR});
      apb(1'b0, 8'h0C, 32'h0000_0000, rd, err);
      chk("slverr", err, 1'b1);
      chk("unmapped_read", rd, 32'h0000_0000);
      $display("test unmapped access done");
      summarize();
   end
endmodule // testbench
